// File: rtl/sbt_consts.vh
// Constants of the serial configuration target.
// Assumes inclusion by bare name from the design file.
`ifndef SBT_CONSTS_VH
`define SBT_CONSTS_VH

// ==========================================
// Register indices
`define SBT_IDX_OE 8'h00
`define SBT_IDX_PLL 8'h01
`define SBT_IDX_SLEW 8'h02
`define SBT_IDX_FSEL 8'h03
`define SBT_IDX_RSV4 8'h04
`define SBT_IDX_REV 8'h05
`define SBT_IDX_DEV 8'h06
`define SBT_IDX_BC 8'h07

// ==========================================
// Field layouts and reset values
`define SBT_EN6_WMASK 8'hDD
`define SBT_OE_RST 8'hDD
`define SBT_SLEW_RST 8'hDD
`define SBT_EN6_RSV1 8'h20
`define SBT_PLL_LAT_HI 7
`define SBT_PLL_LAT_LO 6
`define SBT_PLL_SRC 5
`define SBT_PLL_SW_HI 4
`define SBT_PLL_SW_LO 3
`define SBT_PLL_RSV 2
`define SBT_AMP_HI 1
`define SBT_AMP_LO 0
`define SBT_SRC_RST 1'h0
`define SBT_SW_RST 2'h0
`define SBT_AMP_RST 2'h2
`define SBT_FSEL_RSV1 8'h06
`define SBT_FB_RST 1'h1
`define SBT_RSV4_VAL 8'hFF
`define SBT_BC_RST 5'h08
`define SBT_BC_MSB 4

// ==========================================
// Bus addresses by strap level
`define SBT_ADDR_SELECT_PIN_LOW 2'h0
`define SBT_ADDR_SELECT_PIN_MID 2'h1
`define SBT_ADDR_LOW 7'h6B
`define SBT_ADDR_MID 7'h6C
`define SBT_ADDR_HIGH 7'h6D

// ==========================================
// Bus engine timing
`define SBT_LATCH_CYC 2'h2
`define SBT_LATCH_DONE 2'h3
`define SBT_BITS_LAST 4'h7
`define SBT_BITS_FULL 4'h8

`endif

// File: rtl/sbt_config_target.v
// Serial configuration target: two-wire block read/write engine,
// configuration bytes and the clock output controls they steer.
// Assumes scl/sda and all pins but reset_i and cfg_hold_i are asynchronous to mclk_i, and an
// external open-drain pad resolving sda from sda_oe_n_o.
`timescale 1ns/1ns
`default_nettype none
`include "sbt_consts.vh"

// Contract
// - Host start, write address; target acknowledges
// - Index byte sets first location, acknowledged
// - Write byte count acknowledged by target
// - Data bytes stored consecutively, each acknowledged; a byte arriving with the write buffer full is not acknowledged
// - Read: index, repeated start, read address
// - Target returns count then consecutive bytes
// - Bus address latched from select pin
// - Byte 0 holds six output enables
// - Cleared enable forces output low
// - Byte 1 top bits report latched mode
// - Bit 5 picks pin or software mode
// - Software mode ignored unless bit 5 set
// - Byte 1 low bits select amplitude
// - Byte 7 count field sets readback length; here it is only sent as the count byte, and data runs on until the host nacks
module sbt_config_target #(
	parameter FIFO_AW = 1,
	parameter [7:0] REV_VENDOR = 8'h5A, // Arbitrary value
	parameter [7:0] DEVICE_CODE = 8'hA5 // Arbitrary value
) (
	input wire mclk_i,
	input wire reset_i,
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_n_o,
	input wire [1:0] addr_select_pin_i,
	input wire [1:0] pll_mode_pin_i,
	input wire [5:0] out_en_n_i,
	input wire cfg_hold_i,
	output reg [5:0] dif_run_o,
	output reg [1:0] pll_mode_o,
	output reg [1:0] amplitude_o,
	output reg [5:0] slew_fast_o,
	output reg fb_slew_fast_o
);

	// ==========================================
	// Local encodings
	localparam [2:0] ST_IDLE = 3'h0; // No transaction
	localparam [2:0] ST_RX = 3'h1; // Shifting a byte in
	localparam [2:0] ST_TACK = 3'h2; // Target drives acknowledge
	localparam [2:0] ST_TX = 3'h3; // Shifting a byte out
	localparam [2:0] ST_HACK = 3'h4; // Host answers a byte
	localparam [2:0] ST_IGN = 3'h5; // Wait for start or stop
	localparam [1:0] K_ADDR = 2'h0; // Address byte
	localparam [1:0] K_IDX = 2'h1; // Index byte
	localparam [1:0] K_CNT = 2'h2; // Byte count
	localparam [1:0] K_DATA = 2'h3; // Data byte
	localparam [FIFO_AW:0] FIFO_DEPTH = {1'b1, {FIFO_AW{1'b0}}};

	// Pack the six enable positions of a control byte
	function [5:0] sbt_pack6;
		input [7:0] b;
		begin
			sbt_pack6 = {b[7], b[6], b[4], b[3], b[2], b[0]};
		end
	endfunction

	// ==========================================
	// Synchronisers and edge detection
	reg scl_s1, scl_s2, scl_d; // Bus clock samples
	reg sda_s1, sda_s2, sda_d; // Bus data samples
	reg [1:0] addr_select_pin_s1, addr_select_pin_s2; // Address strap
	reg [1:0] mode_s1, mode_s2; // Mode straps
	reg [5:0] oen_s1, oen_s2; // Per-output enable pins
	wire scl_rise = scl_s2 & ~scl_d;
	wire scl_fall = ~scl_s2 & scl_d;
	// Data edges while the clock stays high frame a transaction
	wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
	wire stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;

	// Two flops on every foreign input except cfg_hold_i; first stage read only here
	always @(posedge mclk_i) begin
		if (reset_i) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
			addr_select_pin_s1 <= 2'h0;
			addr_select_pin_s2 <= 2'h0;
			mode_s1 <= 2'h0;
			mode_s2 <= 2'h0;
			oen_s1 <= 6'h3F;
			oen_s2 <= 6'h3F;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
			addr_select_pin_s1 <= addr_select_pin_i;
			addr_select_pin_s2 <= addr_select_pin_s1;
			mode_s1 <= pll_mode_pin_i;
			mode_s2 <= mode_s1;
			oen_s1 <= out_en_n_i;
			oen_s2 <= oen_s1;
		end
	end

	// ==========================================
	// Strap capture after reset release
	reg [1:0] lat_cnt; // Cycles since release
	reg [6:0] own_addr; // Latched bus address
	reg [1:0] pll_latched; // Latched pin mode
	wire lat_done = (lat_cnt == `SBT_LATCH_DONE);

	// Captured once, after the synchronisers have filled
	always @(posedge mclk_i) begin
		if (reset_i) begin
			lat_cnt <= 2'h0;
			own_addr <= `SBT_ADDR_LOW;
			pll_latched <= 2'h0;
		end else if (!lat_done) begin
			lat_cnt <= lat_cnt + 2'h1;
			if (lat_cnt == `SBT_LATCH_CYC) begin
				case (addr_select_pin_s2)
				`SBT_ADDR_SELECT_PIN_LOW: begin
					own_addr <= `SBT_ADDR_LOW;
				end
				`SBT_ADDR_SELECT_PIN_MID: begin
					own_addr <= `SBT_ADDR_MID;
				end
				default: begin
					own_addr <= `SBT_ADDR_HIGH;
				end
				endcase
				pll_latched <= mode_s2;
			end
		end
	end

	// ==========================================
	// Configuration storage
	reg [7:0] oe_ctrl; // Byte 0, writable bits only
	reg pll_src; // Mode source select
	reg [1:0] pll_sw; // Software mode
	reg [1:0] amp_sel; // Amplitude code
	reg [7:0] slew_ctrl; // Byte 2, writable bits only
	reg fb_slew; // Feedback slew bit
	reg [4:0] bc_field; // Count byte returned on reads
	reg [7:0] ptr; // Current location
	reg [7:0] rd_byte; // Byte at current location

	// Readback mux; reserved bits read as their fixed levels
	always @* begin
		case (ptr)
		`SBT_IDX_OE: begin
			rd_byte = oe_ctrl | `SBT_EN6_RSV1;
		end
		`SBT_IDX_PLL: begin
			rd_byte = {pll_latched, pll_src, pll_sw, 1'b1, amp_sel};
		end
		`SBT_IDX_SLEW: begin
			rd_byte = slew_ctrl | `SBT_EN6_RSV1;
		end
		`SBT_IDX_FSEL: begin
			rd_byte = `SBT_FSEL_RSV1 | {7'h00, fb_slew};
		end
		`SBT_IDX_RSV4: begin
			rd_byte = `SBT_RSV4_VAL;
		end
		`SBT_IDX_REV: begin
			rd_byte = REV_VENDOR;
		end
		`SBT_IDX_DEV: begin
			rd_byte = DEVICE_CODE;
		end
		`SBT_IDX_BC: begin
			rd_byte = {3'h0, bc_field};
		end
		default: begin
			rd_byte = 8'h00; // Unmapped locations read zero
		end
		endcase
	end

	// ==========================================
	// Two-entry write buffer between engine and registers
	reg [15:0] fifo_mem [0:(1 << FIFO_AW) - 1]; // {index, data}
	reg [FIFO_AW-1:0] wr_ptr, rd_ptr; // Slot pointers
	reg [FIFO_AW:0] fill; // Occupied slots
	reg push; // Engine offers a word
	reg [15:0] push_word; // Word on offer
	wire fifo_ready = (fill != FIFO_DEPTH);
	wire fifo_valid = (fill != {(FIFO_AW+1){1'b0}});
	// Holding the drain lets the buffer really fill
	wire pop = fifo_valid & ~cfg_hold_i;
	wire [15:0] pop_word = fifo_mem[rd_ptr];

	// Engine only pushes when fifo_ready was seen
	always @(posedge mclk_i) begin
		if (reset_i) begin
			wr_ptr <= {FIFO_AW{1'b0}};
			rd_ptr <= {FIFO_AW{1'b0}};
			fill <= {(FIFO_AW+1){1'b0}};
		end else begin
			if (push) begin
				fifo_mem[wr_ptr] <= push_word;
				wr_ptr <= wr_ptr + {{(FIFO_AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr <= rd_ptr + {{(FIFO_AW-1){1'b0}}, 1'b1};
			end
			case ({push, pop})
			2'b10: begin
				fill <= fill + {{FIFO_AW{1'b0}}, 1'b1};
			end
			2'b01: begin
				fill <= fill - {{FIFO_AW{1'b0}}, 1'b1};
			end
			default: begin
				fill <= fill;
			end
			endcase
		end
	end

	// Drained words land in the register addressed by their index
	always @(posedge mclk_i) begin
		if (reset_i) begin
			oe_ctrl <= `SBT_OE_RST;
			pll_src <= `SBT_SRC_RST;
			pll_sw <= `SBT_SW_RST;
			amp_sel <= `SBT_AMP_RST;
			slew_ctrl <= `SBT_SLEW_RST;
			fb_slew <= `SBT_FB_RST;
			bc_field <= `SBT_BC_RST;
		end else if (pop) begin
			case (pop_word[15:8])
			`SBT_IDX_OE: begin
				oe_ctrl <= pop_word[7:0] & `SBT_EN6_WMASK;
			end
			`SBT_IDX_PLL: begin
				// Readback bits 7:6 are not writable
				pll_src <= pop_word[`SBT_PLL_SRC];
				pll_sw <= pop_word[`SBT_PLL_SW_HI:`SBT_PLL_SW_LO];
				amp_sel <= pop_word[`SBT_AMP_HI:`SBT_AMP_LO];
			end
			`SBT_IDX_SLEW: begin
				slew_ctrl <= pop_word[7:0] & `SBT_EN6_WMASK;
			end
			`SBT_IDX_FSEL: begin
				fb_slew <= pop_word[0];
			end
			`SBT_IDX_BC: begin
				bc_field <= pop_word[`SBT_BC_MSB:0];
			end
			default: begin
				oe_ctrl <= oe_ctrl; // Read-only or unmapped: dropped
			end
			endcase
		end
	end

	// ==========================================
	// Clock output controls
	// Registered so every output comes from a flop
	always @(posedge mclk_i) begin
		if (reset_i) begin
			dif_run_o <= 6'h00;
			pll_mode_o <= 2'h0;
			amplitude_o <= `SBT_AMP_RST;
			slew_fast_o <= 6'h3F;
			fb_slew_fast_o <= `SBT_FB_RST;
		end else begin
			// Both legs low when the bit is clear, whatever the pin
			dif_run_o <= sbt_pack6(oe_ctrl) & ~oen_s2;
			// Software code has no path unless the source bit is set
			pll_mode_o <= pll_src ? pll_sw : pll_latched;
			amplitude_o <= amp_sel;
			slew_fast_o <= sbt_pack6(slew_ctrl);
			fb_slew_fast_o <= fb_slew;
		end
	end

	// ==========================================
	// Bus engine
	reg [2:0] state; // Engine state
	reg [1:0] kind; // Kind of byte being received
	reg [3:0] bitcnt; // Bits shifted in this byte
	reg [7:0] shreg; // Shift register, both directions
	reg rd_mode; // Direction from the address byte
	reg rd_first; // Next byte out is the count
	wire [7:0] tx_byte = rd_first ? {3'h0, bc_field} : rd_byte;

	// Sda changes only after scl falls, so never frames a start
	always @(posedge mclk_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			kind <= K_ADDR;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			rd_mode <= 1'b0;
			rd_first <= 1'b0;
			ptr <= 8'h00;
			push <= 1'b0;
			push_word <= 16'h0000;
			sda_o <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end else begin
			push <= 1'b0;
			sda_o <= 1'b0; // Open drain: only ever pulls low
			if (!lat_done) begin
				state <= ST_IDLE; // Address not yet known
			end else if (start_det) begin
				// Start or repeated start restarts address reception
				state <= ST_RX;
				kind <= K_ADDR;
				bitcnt <= 4'h0;
				sda_oe_n_o <= 1'b1;
			end else if (stop_det) begin
				state <= ST_IDLE;
				sda_oe_n_o <= 1'b1;
			end else begin
				case (state)
				ST_RX: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_s2};
						bitcnt <= bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == `SBT_BITS_FULL) begin
						bitcnt <= 4'h0;
						case (kind)
						K_ADDR: begin
							if (shreg[7:1] == own_addr) begin
								sda_oe_n_o <= 1'b0;
								state <= ST_TACK;
								rd_mode <= shreg[0];
								rd_first <= 1'b1;
								kind <= K_IDX;
							end else begin
								state <= ST_IGN;
							end
						end
						K_IDX: begin
							ptr <= shreg;
							sda_oe_n_o <= 1'b0;
							state <= ST_TACK;
							kind <= K_CNT;
						end
						K_CNT: begin
							// Count is acknowledged; stop ends the data
							sda_oe_n_o <= 1'b0;
							state <= ST_TACK;
							kind <= K_DATA;
						end
						default: begin
							if (fifo_ready) begin
								push <= 1'b1;
								push_word <= {ptr, shreg};
								ptr <= ptr + 8'h01;
								sda_oe_n_o <= 1'b0;
								state <= ST_TACK;
							end else begin
								state <= ST_IGN; // Full buffer: byte refused
							end
						end
						endcase
					end
				end
				ST_TACK: begin
					if (scl_fall) begin
						if (rd_mode) begin
							// First byte out is the count, then data
							// Count flag stays set until the host answers it,
							// so the pointer does not step past location N
							shreg <= tx_byte;
							sda_oe_n_o <= tx_byte[7];
							bitcnt <= 4'h0;
							state <= ST_TX;
						end else begin
							sda_oe_n_o <= 1'b1;
							state <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bitcnt == `SBT_BITS_LAST) begin
							sda_oe_n_o <= 1'b1; // Release for host answer
							state <= ST_HACK;
						end else begin
							sda_oe_n_o <= shreg[6];
							shreg <= {shreg[6:0], 1'b0};
							bitcnt <= bitcnt + 4'h1;
						end
					end
				end
				ST_HACK: begin
					if (scl_rise) begin
						if (sda_s2) begin
							state <= ST_IGN;
						end
					end else if (scl_fall) begin
						// Acknowledged: next location goes out
						shreg <= rd_byte;
						sda_oe_n_o <= rd_byte[7];
						bitcnt <= 4'h0;
						rd_first <= 1'b0; // Count answered; data bytes follow
						state <= ST_TX;
					end
				end
				default: begin
					sda_oe_n_o <= 1'b1; // Idle or ignoring: bus released
				end
				endcase
				// Pointer steps once the host has taken a data byte
				if (state == ST_HACK && scl_rise && !sda_s2 && !rd_first) begin
					ptr <= ptr + 8'h01;
				end
			end
		end
	end

endmodule
`default_nettype wire

// File: bench/sbt_host_model.sv
// Bus host model: drives the link clock and pulls the data line.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module sbt_host_model (
	output logic scl_o, // Link clock, high when idle
	output logic pull_o, // 1 pulls data low
	input wire logic sda_i // Resolved data line
);
	// ==========
	// Quarter of the 400 ns link period
	localparam int Q = 100;
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	// Start or repeated start; first step snaps to a 100 ns grid
	// so link edges never share a time step with a rising system clock edge
	task automatic start;
		#(Q - $time % Q) pull_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q pull_o = 1'b1;
		#Q scl_o = 1'b0;
	endtask
	// Stop after the last ack or nack
	task automatic stop;
		#Q pull_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q pull_o = 1'b0;
	endtask
	// One bit slot; data set mid-low, sampled mid-high
	task automatic slot(input logic b, output logic r);
		#Q pull_o = !b;
		#Q scl_o = 1'b1;
		#Q r = sda_i;
		#Q scl_o = 1'b0;
	endtask
	// Byte out MSB first; ack high when the target pulled low
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			slot(d[i], r);
		slot(1'b1, r);
		ack = !r;
	endtask
	// Byte in; nack only on the last byte
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			slot(1'b1, d[i]);
		slot(last, r);
	endtask
endmodule
`default_nettype wire

// File: bench/sbt_config_target_chk.sv
// Checker on the configuration target's pins and outputs.
// Assumes one mclk_i domain; bound at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module sbt_config_target_chk (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic [1:0] addr_select_pin_i,
	input wire logic [1:0] pll_mode_pin_i,
	input wire logic [5:0] out_en_n_i,
	input wire logic cfg_hold_i,
	input wire logic [5:0] dif_run_o,
	input wire logic [1:0] pll_mode_o,
	input wire logic [1:0] amplitude_o,
	input wire logic [5:0] slew_fast_o,
	input wire logic fb_slew_fast_o
);
	// ==========
	// Helper logic
	logic [3:0] up; // Cycles since reset, saturating
	logic [3:0] scl_hi; // Cycles of link clock high
	logic [3:0] hold_lo; // Cycles since the drain stall ended
	logic [5:0] p1, p2, p3, p4; // Enable pin history
	// Saturating counters; history covers the pin synchroniser
	always @(posedge mclk_i) begin
		up <= reset_i ? 4'h0 : up + {3'h0, up != 4'hF};
		scl_hi <= reset_i || !scl_i ? 4'h0 : scl_hi + {3'h0, scl_hi != 4'hF};
		hold_lo <= reset_i || cfg_hold_i ? 4'h0 : hold_lo + {3'h0, hold_lo != 4'hF};
		p1 <= out_en_n_i;
		p2 <= p1;
		p3 <= p2;
		p4 <= p3;
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);
	// ==========
	// Properties
	property p_reset_vals;
		$fell(reset_i) |-> sda_oe_n_o && dif_run_o == 6'h00 && amplitude_o == 2'h2
			&& slew_fast_o == 6'h3F && fb_slew_fast_o && pll_mode_o == 2'h0;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset");
	property p_drive_in_low;
		$fell(sda_oe_n_o) |-> !scl_i;
	endproperty
	a_drive_in_low: assert property (p_drive_in_low) else $error("drive in high");
	property p_ack_stands;
		$fell(sda_oe_n_o) |=> (!sda_oe_n_o) [*4];
	endproperty
	a_ack_stands: assert property (p_ack_stands) else $error("short drive");
	property p_quiet_high;
		scl_i && $past(scl_i) && $past(scl_i, 2) && $past(scl_i, 3) |-> $stable(sda_oe_n_o);
	endproperty
	a_quiet_high: assert property (p_quiet_high) else $error("data moved");
	property p_idle_released;
		scl_hi == 4'hF |-> sda_oe_n_o;
	endproperty
	a_idle_released: assert property (p_idle_released) else $error("idle drive");
	property p_pin_override;
		up > 4'h5 |-> (dif_run_o & p1 & p2 & p3 & p4) == 6'h00;
	endproperty
	a_pin_override: assert property (p_pin_override) else $error("pin ignored");
	property p_pins_ignored;
		up == 4'hF && $changed(pll_mode_pin_i) |=> $stable(pll_mode_o) [*4];
	endproperty
	a_pins_ignored: assert property (p_pins_ignored) else $error("mode moved");
	property p_cfg_in_frame;
		up == 4'hF && scl_hi == 4'hF && hold_lo == 4'hF
			|-> $stable(amplitude_o) && $stable(pll_mode_o);
	endproperty
	a_cfg_in_frame: assert property (p_cfg_in_frame) else $error("idle change");
endmodule
bind sbt_config_target sbt_config_target_chk i_chk (
	.mclk_i(mclk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_n_o(sda_oe_n_o), .addr_select_pin_i(addr_select_pin_i),
	.pll_mode_pin_i(pll_mode_pin_i), .out_en_n_i(out_en_n_i), .cfg_hold_i(cfg_hold_i),
	.dif_run_o(dif_run_o), .pll_mode_o(pll_mode_o), .amplitude_o(amplitude_o),
	.slew_fast_o(slew_fast_o), .fb_slew_fast_o(fb_slew_fast_o)
);
`default_nettype wire

// File: bench/test_smbus_block_config_target.sv
// Bench top: register transactions through the host model.
// Assumes a pull-up on the data line, resolved here.
`timescale 1ns/1ns
`default_nettype none
module test_smbus_block_config_target;
	// ==========
	// Signals
	logic mclk_i, reset_i, cfg_hold_i; // Clock, reset, drain stall
	logic [1:0] sel, pin_mode, pll, amp; // Straps, mode, amplitude
	logic [5:0] en_n, run, slew; // Enable pins and outputs
	logic sda_o, oe_n, fb, scl, pull, sda, a; // Link and ack
	logic [7:0] v; // Byte read back
	logic [6:0] tgt = 7'h6C; // Target bus address in use
	int err_count, num_checks; // Tallies
	// Open-drain data line with pull-up
	assign sda = !pull && oe_n !== 1'b0;
	sbt_config_target i_dut (
		.mclk_i(mclk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n_o(oe_n), .addr_select_pin_i(sel), .pll_mode_pin_i(pin_mode),
		.out_en_n_i(en_n), .cfg_hold_i(cfg_hold_i), .dif_run_o(run), .pll_mode_o(pll),
		.amplitude_o(amp), .slew_fast_o(slew), .fb_slew_fast_o(fb)
	);
	sbt_host_model i_host (.scl_o(scl), .pull_o(pull), .sda_i(sda));
	// ==========
	// Tasks
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic ack_is(input logic e);
		check({7'h0, a}, {7'h0, e});
	endtask
	// Start, current target address for write, first location
	task automatic idx_hdr(input logic [7:0] idx);
		i_host.start();
		i_host.wbyte({tgt, 1'b0}, a);
		ack_is(1'b1);
		i_host.wbyte(idx, a);
		ack_is(1'b1);
	endtask
	// Block write of n bytes, top byte of d first
	task automatic wr(input logic [7:0] idx, input int n, input logic [23:0] d,
			input logic [2:0] ex);
		idx_hdr(idx);
		i_host.wbyte(n[7:0], a);
		ack_is(1'b1);
		for (int i = 0; i < n; i++) begin
			i_host.wbyte(d[23-8*i -: 8], a);
			ack_is(ex[2-i]);
		end
		i_host.stop();
	endtask
	// Block read of n bytes; bc is the count byte expected
	task automatic rd(input logic [7:0] idx, input logic [7:0] bc, input int n,
			input logic [15:0] e);
		idx_hdr(idx);
		i_host.start();
		i_host.wbyte({tgt, 1'b1}, a);
		ack_is(1'b1);
		i_host.rbyte(1'b0, v);
		check(v, bc);
		for (int i = 0; i < n; i++) begin
			i_host.rbyte(i == n - 1, v);
			check(v, e[15-8*i -: 8]);
		end
		i_host.stop();
	endtask
	task automatic finish_test;
		$display("Checks %0d, errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========
	// Clock and watchdog, the latter far beyond the run
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	initial begin
		#2000000;
		err_count++;
		finish_test();
	end
	// ==========
	// Sequence
	initial begin
		reset_i <= 1'b1;
		cfg_hold_i <= 1'b0;
		sel <= 2'h1;
		pin_mode <= 2'h2;
		en_n <= 6'h00;
		repeat (12) @(posedge mclk_i);
		reset_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		// Defaults and the outputs they steer
		rd(8'h00, 8'h08, 2, 16'hFD86);
		check({2'h0, run}, 8'h3F);
		check({6'h0, pll}, 8'h02);
		// Two bytes; latched mode bits are read-only
		wr(8'h00, 2, 24'h54FF00, 3'h6);
		rd(8'h00, 8'h08, 2, 16'h74BF);
		check({2'h0, run}, 8'h1A);
		check({6'h0, pll}, 8'h03);
		@(posedge mclk_i);
		en_n <= 6'h02;
		repeat (8) @(posedge mclk_i);
		check({2'h0, run}, 8'h18);
		// Every amplitude code; software mode not selected
		for (int k = 0; k < 4; k++) begin
			wr(8'h01, 1, {6'h02, k[1:0], 16'h0000}, 3'h4);
			check({6'h0, amp}, {6'h0, k[1:0]});
			check({6'h0, pll}, 8'h02);
		end
		wr(8'h07, 1, 24'h030000, 3'h4);
		rd(8'h00, 8'h03, 1, 16'h7400);
		// Straps moved after latching; foreign address
		@(posedge mclk_i);
		sel <= 2'h0;
		pin_mode <= 2'h1;
		i_host.start();
		i_host.wbyte(8'hD6, a);
		ack_is(1'b0);
		i_host.wbyte(8'h00, a);
		ack_is(1'b0);
		i_host.stop();
		rd(8'h01, 8'h03, 1, 16'h8F00);
		check({6'h0, pll}, 8'h02);
		// Drain stalled: two buffered, third refused
		@(posedge mclk_i);
		cfg_hold_i <= 1'b1;
		wr(8'h02, 3, 24'h000000, 3'h6);
		check({2'h0, slew}, 8'h3F);
		@(posedge mclk_i);
		cfg_hold_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
		check({2'h0, slew}, 8'h00);
		check({7'h0, fb}, 8'h00);
		check({7'h0, sda_o}, 8'h00);
		// Mid-run reset with the high strap; mode pins relatched
		@(posedge mclk_i);
		reset_i <= 1'b1;
		sel <= 2'h2;
		pin_mode <= 2'h1;
		repeat (12) @(posedge mclk_i);
		reset_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		tgt = 7'h6D;
		rd(8'h01, 8'h08, 1, 16'h4600);
		check({6'h0, pll}, 8'h01);
		check({2'h0, run}, 8'h3D);
		check({6'h0, amp}, 8'h02);
		finish_test();
	end
endmodule
`default_nettype wire
